// ===== design/pagpm_axil.v
// Purpose: AXI4-Lite slave front end, one write and one read under way at a time
// Assumes: register decode and read mux live in the caller
// Notes:   write strobe to the register file is a one-cycle pulse
`timescale 1ns/1ps
`include "pagpm_regs.vh"
module pagpm_axil (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [11:0] s_awaddr,
  input  wire        s_awvalid,
  output wire        s_awready,
  input  wire [31:0] s_wdata,
  input  wire [3:0]  s_wstrb,
  input  wire        s_wvalid,
  output wire        s_wready,
  output reg  [1:0]  s_bresp,
  output reg         s_bvalid,
  input  wire        s_bready,
  input  wire [11:0] s_araddr,
  input  wire        s_arvalid,
  output wire        s_arready,
  output reg  [31:0] s_rdata,
  output reg  [1:0]  s_rresp,
  output reg         s_rvalid,
  input  wire        s_rready,
  output wire        wr_en,
  output wire [9:0]  wr_idx,
  output wire [7:0]  wr_data,
  output wire        wr_lane0,
  input  wire        wr_hit,
  output wire [9:0]  rd_idx,
  input  wire [7:0]  rd_data,
  input  wire        rd_hit
);
  reg        aw_full;
  reg        w_full;
  reg [9:0]  aw_idx;
  reg [7:0]  w_byte;
  reg        w_lane0;

  // no new write is taken while a response waits, so the pulse fires once per write
  assign s_awready = ~aw_full & ~s_bvalid;
  assign s_wready  = ~w_full & ~s_bvalid;
  assign wr_en     = aw_full & w_full & ~s_bvalid;
  assign wr_idx    = aw_idx;
  assign wr_data   = w_byte;
  assign wr_lane0  = w_lane0;
  assign s_arready = ~s_rvalid;
  assign rd_idx    = s_araddr[11:2];

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full  <= 1'b0;
      w_full   <= 1'b0;
      aw_idx   <= 10'h000;
      w_byte   <= 8'h00;
      w_lane0  <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp  <= `PAGPM_RESP_OKAY;
      s_rvalid <= 1'b0;
      s_rresp  <= `PAGPM_RESP_OKAY;
      s_rdata  <= 32'h0000_0000;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_full <= 1'b1;
        aw_idx  <= s_awaddr[11:2];
      end
      if (s_wvalid && s_wready) begin
        w_full  <= 1'b1;
        w_byte  <= s_wdata[7:0];
        w_lane0 <= s_wstrb[0];
      end
      if (wr_en) begin
        aw_full  <= 1'b0;
        w_full   <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= wr_hit ? `PAGPM_RESP_OKAY : `PAGPM_RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata  <= {24'h00_0000, rd_data};
        s_rresp  <= rd_hit ? `PAGPM_RESP_OKAY : `PAGPM_RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end
endmodule // pagpm_axil

// ===== design/pagpm_regs.vh
// Purpose: register indices, field positions, reset values and mode codes of the port block
// Assumes: byte address of a register is four times its index
// Notes:   shared by the port top and its bus slave
`ifndef PAGPM_REGS_VH
`define PAGPM_REGS_VH

// register indices (byte address = index * 4)
`define PAGPM_IDX_PORT_DATA   10'h005
`define PAGPM_IDX_T1_CTRL     10'h010
`define PAGPM_IDX_SSP_CTRL    10'h014
`define PAGPM_IDX_ADC_CTRL0   10'h01f
`define PAGPM_IDX_OPTION      10'h081
`define PAGPM_IDX_PORT_DIR    10'h085
`define PAGPM_IDX_ANALOG_SEL  10'h091
`define PAGPM_IDX_CMP_CTRL0   10'h09c
`define PAGPM_IDX_LCD_CTRL    10'h107
`define PAGPM_IDX_LCD_SE_LO   10'h11c
`define PAGPM_IDX_LCD_SE_HI   10'h11d

// reset values
`define PAGPM_RST_PORT_DATA   8'h00
`define PAGPM_RST_T1_CTRL     8'h00
`define PAGPM_RST_SSP_CTRL    8'h00
`define PAGPM_RST_ADC_CTRL0   8'h00
`define PAGPM_RST_OPTION      8'hff
`define PAGPM_RST_PORT_DIR    8'hff
`define PAGPM_RST_ANALOG_SEL  8'hff
`define PAGPM_RST_CMP_CTRL0   6'h00
`define PAGPM_RST_LCD_CTRL    8'h13
`define PAGPM_RST_LCD_SE      8'h00

// field positions
`define PAGPM_LCD_EN_BIT      7
`define PAGPM_LCD_MUX_HI      1
`define PAGPM_LCD_MUX_LO      0
`define PAGPM_T1_OSC_EN_BIT   3
`define PAGPM_CMP1_OUT_BIT    6
`define PAGPM_CMP2_OUT_BIT    7
`define PAGPM_CMP_MODE_HI     2
`define PAGPM_CMP_MODE_LO     0
`define PAGPM_CRYSTAL_PINS    8'hc0
`define PAGPM_DRIVABLE_PINS   8'hf7

// codes
`define PAGPM_MUX_QUAD        2'h3
`define PAGPM_MUX_TRIPLE      2'h2
`define PAGPM_CM_OFF          3'h7
`define PAGPM_CM_OUTPUTS      3'h6
`define PAGPM_OSC_LOW_POWER   3'h0
`define PAGPM_OSC_STANDARD    3'h1
`define PAGPM_OSC_HIGH_SPEED  3'h2
`define PAGPM_OSC_EC          3'h3
`define PAGPM_OSC_INTIO       3'h4
`define PAGPM_OSC_INTCLKO     3'h5
`define PAGPM_OSC_RCIO        3'h6
`define PAGPM_OSC_RCCLKO      3'h7

`define PAGPM_RESP_OKAY       2'h0
`define PAGPM_RESP_SLVERR     2'h2

`endif

// ===== design/pagpm_top.v
// Purpose: eight-pin general purpose port with per-pin direction and alternate function mux
// Assumes: pads sampled synchronously to ref_clk; peripherals sit outside this block
// Notes:   rst_n is the power-on / brown-out reset, other_reset_req a synchronous other reset
//
// What this block does
// - direction one tri-states, zero drives latch
// - crystal modes read direction bits 7:6 as one
// - pin0: gpio, converter0, comparator1 minus, segment12
// - pin1: gpio, converter1, comparator2 minus, segment7
// - pin2: gpio, converter2, comparator2 plus, vref, common2
// - pin3 input only; converter3, vref, common3/segment15
// - pin3 lcd mode: enable and (seg15 or quad mux without fourth port)
// - pin4: gpio, comparator1 out, timer0 clock, segment4
// - pin5: gpio, comparator2 out, slave select, segment5, converter4
// - pin6: gpio, crystal out, clock out, timer1 osc
// - pin7: gpio, crystal in, clock in, timer1 osc
// - segment enables reset only by power-on
// - data read gives pins, write updates latch
// - analog pins read as zero
// - analog pins after power-up: 5 and 3:0
// - direction still gates driver on analog pins
`timescale 1ns/1ps
`include "pagpm_regs.vh"
module pagpm_top (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        other_reset_req,
  input  wire [11:0] s_awaddr,
  input  wire        s_awvalid,
  output wire        s_awready,
  input  wire [31:0] s_wdata,
  input  wire [3:0]  s_wstrb,
  input  wire        s_wvalid,
  output wire        s_wready,
  output wire [1:0]  s_bresp,
  output wire        s_bvalid,
  input  wire        s_bready,
  input  wire [11:0] s_araddr,
  input  wire        s_arvalid,
  output wire        s_arready,
  output wire [31:0] s_rdata,
  output wire [1:0]  s_rresp,
  output wire        s_rvalid,
  input  wire        s_rready,
  input  wire [7:0]  pad_in,
  output reg  [7:0]  pad_out,
  output reg  [7:0]  pad_oe,
  input  wire [2:0]  osc_mode,
  input  wire        has_fourth_port,
  input  wire        comparator1_output,
  input  wire        comparator2_output,
  input  wire        clock_output_src,
  output reg  [7:0]  pin_analog_mode,
  output reg  [7:0]  pin_lcd_mode_active,
  output reg         timer0_ext_clock_in,
  output reg         slave_select_in,
  output reg         crystal_input,
  output reg         timer1_osc_input,
  output reg  [7:0]  timer1_control,
  output reg  [7:0]  sync_serial_control,
  output reg  [7:0]  converter_control0,
  output reg  [7:0]  option_settings,
  output reg  [7:0]  lcd_control
);
  reg  [7:0] first_port_data;
  reg  [7:0] first_port_direction;
  reg  [7:0] analog_pin_select;
  reg  [5:0] comparator_control0;
  reg  [7:0] lcd_segment_enable_low;
  reg  [7:0] lcd_segment_enable_high;

  wire       wr_en;
  wire [9:0] wr_idx;
  wire [7:0] wr_data;
  wire       wr_lane0;
  wire [9:0] rd_idx;
  reg  [7:0] rd_data;
  wire       rd_hit;
  wire       wr_hit;

  // one decode sets the bus response of both reads and writes
  function is_mapped;
    input [9:0] idx;
    begin
      case (idx)
        `PAGPM_IDX_PORT_DATA,
        `PAGPM_IDX_T1_CTRL,
        `PAGPM_IDX_SSP_CTRL,
        `PAGPM_IDX_ADC_CTRL0,
        `PAGPM_IDX_OPTION,
        `PAGPM_IDX_PORT_DIR,
        `PAGPM_IDX_ANALOG_SEL,
        `PAGPM_IDX_CMP_CTRL0,
        `PAGPM_IDX_LCD_CTRL,
        `PAGPM_IDX_LCD_SE_LO,
        `PAGPM_IDX_LCD_SE_HI: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // the three crystal modes hand both oscillator pins to the oscillator
  function is_crystal;
    input [2:0] mode;
    begin
      is_crystal = (mode == `PAGPM_OSC_LOW_POWER) || (mode == `PAGPM_OSC_STANDARD) ||
                   (mode == `PAGPM_OSC_HIGH_SPEED);
    end
  endfunction

  assign rd_hit = is_mapped(rd_idx);
  assign wr_hit = is_mapped(wr_idx);

  pagpm_axil u_axil (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_en     (wr_en),
    .wr_idx    (wr_idx),
    .wr_data   (wr_data),
    .wr_lane0  (wr_lane0),
    .wr_hit    (wr_hit),
    .rd_idx    (rd_idx),
    .rd_data   (rd_data),
    .rd_hit    (rd_hit)
  );

  // only byte lane 0 carries a register; a write without it is answered and ignored
  wire       wr_go = wr_en & wr_lane0;
  wire [1:0] lcd_multiplex_select = lcd_control[`PAGPM_LCD_MUX_HI:`PAGPM_LCD_MUX_LO];
  wire       lcd_on = lcd_control[`PAGPM_LCD_EN_BIT];
  wire [2:0] cm    = comparator_control0[`PAGPM_CMP_MODE_HI:`PAGPM_CMP_MODE_LO];
  wire       t1_osc = timer1_control[`PAGPM_T1_OSC_EN_BIT];

  // pin function decode
  reg  [7:0] next_analog;
  reg  [7:0] next_lcd;
  reg  [7:0] alt_oe;
  reg  [7:0] alt_val;
  reg  [7:0] osc_owned;
  reg        cmp_analog;
  reg        crystal;
  always @* begin
    crystal    = is_crystal(osc_mode);
    // comparators hold their input pins analog until switched fully off
    cmp_analog = (cm != `PAGPM_CM_OFF);
    next_analog = 8'h00;
    next_analog[0] = analog_pin_select[0] | cmp_analog;
    next_analog[1] = analog_pin_select[1] | cmp_analog;
    next_analog[2] = analog_pin_select[2] | cmp_analog;
    next_analog[3] = analog_pin_select[3] | cmp_analog;
    next_analog[5] = analog_pin_select[4];
    next_lcd = 8'h00;
    next_lcd[0] = lcd_on & lcd_segment_enable_high[4];
    next_lcd[1] = lcd_on & lcd_segment_enable_low[7];
    // common 2 is in use from triple multiplex upwards
    next_lcd[2] = lcd_on & lcd_multiplex_select[1];
    next_lcd[3] = lcd_on & (lcd_segment_enable_high[7] |
                  (~has_fourth_port & (lcd_multiplex_select == `PAGPM_MUX_QUAD)));
    next_lcd[4] = lcd_on & lcd_segment_enable_low[4];
    next_lcd[5] = lcd_on & lcd_segment_enable_low[5];
    alt_oe  = 8'h00;
    alt_val = 8'h00;
    // comparator outputs take the pin whatever its direction bit says
    alt_oe[4]  = (cm == `PAGPM_CM_OUTPUTS) & ~next_lcd[4];
    alt_val[4] = comparator1_output;
    alt_oe[5]  = (cm == `PAGPM_CM_OUTPUTS) & ~next_lcd[5];
    alt_val[5] = comparator2_output;
    alt_oe[6]  = (osc_mode == `PAGPM_OSC_INTCLKO) ||
                 (osc_mode == `PAGPM_OSC_RCCLKO);
    alt_val[6] = clock_output_src;
    osc_owned = 8'h00;
    osc_owned[6] = crystal | alt_oe[6] | (t1_osc & ~alt_oe[6]);
    // every mode except the internal ones takes its clock from pin 7
    osc_owned[7] = crystal | t1_osc |
                   ~((osc_mode == `PAGPM_OSC_INTIO) ||
                     (osc_mode == `PAGPM_OSC_INTCLKO));
  end

  // gpio driver: analog does not override direction, ownership does
  // pin 3 has no output stage at all, whatever its direction bit holds
  wire [7:0] gpio_oe = ~first_port_direction & ~next_lcd & ~alt_oe & ~osc_owned
                       & `PAGPM_DRIVABLE_PINS;
  wire [7:0] pin_read = pad_in & ~next_analog;
  // only the read-back is forced; the stored bits keep what software wrote
  wire [7:0] dir_read = crystal ? (first_port_direction | `PAGPM_CRYSTAL_PINS)
                                : first_port_direction;

  always @* begin
    rd_data = 8'h00;
    case (rd_idx)
      `PAGPM_IDX_PORT_DATA:  rd_data = pin_read;
      `PAGPM_IDX_T1_CTRL:    rd_data = timer1_control;
      `PAGPM_IDX_SSP_CTRL:   rd_data = sync_serial_control;
      `PAGPM_IDX_ADC_CTRL0:  rd_data = converter_control0;
      `PAGPM_IDX_OPTION:     rd_data = option_settings;
      `PAGPM_IDX_PORT_DIR:   rd_data = dir_read;
      `PAGPM_IDX_ANALOG_SEL: rd_data = analog_pin_select;
      `PAGPM_IDX_CMP_CTRL0: begin
        // the result bits show the comparators live; writes to them are dropped
        rd_data                      = {2'b00, comparator_control0};
        rd_data[`PAGPM_CMP1_OUT_BIT] = comparator1_output;
        rd_data[`PAGPM_CMP2_OUT_BIT] = comparator2_output;
      end
      `PAGPM_IDX_LCD_CTRL:   rd_data = lcd_control;
      `PAGPM_IDX_LCD_SE_LO:  rd_data = lcd_segment_enable_low;
      `PAGPM_IDX_LCD_SE_HI:  rd_data = lcd_segment_enable_high;
      default:               rd_data = 8'h00;
    endcase
  end

  // registers set back to their reset values by every reset
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_port_direction <= `PAGPM_RST_PORT_DIR;
      sync_serial_control  <= `PAGPM_RST_SSP_CTRL;
      converter_control0   <= `PAGPM_RST_ADC_CTRL0;
      option_settings      <= `PAGPM_RST_OPTION;
      analog_pin_select    <= `PAGPM_RST_ANALOG_SEL;
      comparator_control0  <= `PAGPM_RST_CMP_CTRL0;
      lcd_control          <= `PAGPM_RST_LCD_CTRL;
    end else if (other_reset_req) begin
      first_port_direction <= `PAGPM_RST_PORT_DIR;
      sync_serial_control  <= `PAGPM_RST_SSP_CTRL;
      converter_control0   <= `PAGPM_RST_ADC_CTRL0;
      option_settings      <= `PAGPM_RST_OPTION;
      analog_pin_select    <= `PAGPM_RST_ANALOG_SEL;
      comparator_control0  <= `PAGPM_RST_CMP_CTRL0;
      lcd_control          <= `PAGPM_RST_LCD_CTRL;
    end else if (wr_go) begin
      case (wr_idx)
        `PAGPM_IDX_PORT_DIR:   first_port_direction <= wr_data;
        `PAGPM_IDX_SSP_CTRL:   sync_serial_control  <= wr_data;
        `PAGPM_IDX_ADC_CTRL0:  converter_control0   <= wr_data;
        `PAGPM_IDX_OPTION:     option_settings      <= wr_data;
        `PAGPM_IDX_ANALOG_SEL: analog_pin_select    <= wr_data;
        `PAGPM_IDX_CMP_CTRL0:  comparator_control0  <= wr_data[5:0];
        `PAGPM_IDX_LCD_CTRL:   lcd_control          <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // registers that only the power-on / brown-out reset initialises
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_port_data         <= `PAGPM_RST_PORT_DATA;
      timer1_control          <= `PAGPM_RST_T1_CTRL;
      lcd_segment_enable_low  <= `PAGPM_RST_LCD_SE;
      lcd_segment_enable_high <= `PAGPM_RST_LCD_SE;
    end else if (wr_go && !other_reset_req) begin
      case (wr_idx)
        // whole-byte write of the read-modify-write sequence lands in the latch
        `PAGPM_IDX_PORT_DATA: first_port_data         <= wr_data;
        `PAGPM_IDX_T1_CTRL:   timer1_control          <= wr_data;
        `PAGPM_IDX_LCD_SE_LO: lcd_segment_enable_low  <= wr_data;
        `PAGPM_IDX_LCD_SE_HI: lcd_segment_enable_high <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // pad drive and peripheral taps are registered; one cycle behind the registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out             <= 8'h00;
      pad_oe              <= 8'h00;
      pin_analog_mode     <= 8'h00;
      pin_lcd_mode_active <= 8'h00;
      timer0_ext_clock_in <= 1'b0;
      slave_select_in     <= 1'b0;
      crystal_input       <= 1'b0;
      timer1_osc_input    <= 1'b0;
    end else begin
      pad_oe              <= gpio_oe | alt_oe;
      pad_out             <= (alt_oe & alt_val) | (~alt_oe & first_port_data);
      pin_analog_mode     <= next_analog;
      pin_lcd_mode_active <= next_lcd;
      timer0_ext_clock_in <= pad_in[4];
      slave_select_in     <= pad_in[5];
      crystal_input       <= pad_in[7] & osc_owned[7];
      timer1_osc_input    <= pad_in[7] & t1_osc;
    end
  end
endmodule // pagpm_top

// ===== tb/pagpm_asserts.sv
// Purpose: pin ownership and copy checks on the port's ports
// Assumes: rst_n is the power-on reset
// Notes:   pin outputs lag the registers and osc_mode by one edge
`timescale 1ns/1ps
module pagpm_asserts (
  input wire       ref_clk,
  input wire       rst_n,
  input wire       other_reset_req,
  input wire [7:0] pad_in,
  input wire [7:0] pad_out,
  input wire [7:0] pad_oe,
  input wire [2:0] osc_mode,
  input wire       clock_output_src,
  input wire [7:0] pin_analog_mode,
  input wire [7:0] pin_lcd_mode_active,
  input wire       timer0_ext_clock_in,
  input wire       slave_select_in,
  input wire       timer1_osc_input,
  input wire [7:0] timer1_control,
  input wire [7:0] lcd_control
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_pin3_no_drive: assert property (!pad_oe[3]) else $error("pin3 driven");
  a_lcd_blocks_oe: assert property ((pin_lcd_mode_active & pad_oe) == 8'h00)
    else $error("lcd pin driven");
  a_pin3_lcd_en: assert property (pin_lcd_mode_active[3] |-> $past(lcd_control[7]))
    else $error("pin3 lcd without enable");
  a_t0_clk_copy: assert property ($past(rst_n) |-> timer0_ext_clock_in == $past(pad_in[4]))
    else $error("timer0 clock copy");
  a_ss_copy: assert property ($past(rst_n) |-> slave_select_in == $past(pad_in[5]))
    else $error("slave select copy");
  a_t1osc_off: assert property (!timer1_control[3] && !$past(timer1_control[3])
    && !$past(timer1_control[3], 2) |-> !timer1_osc_input) else $error("t1 osc leak");
  a_clkout_pin6: assert property ($past(rst_n) && $past(osc_mode) == 3'h5
    |-> pad_oe[6] && pad_out[6] == $past(clock_output_src)) else $error("clock out");
  a_crystal_quiet: assert property ($past(rst_n) && $past(osc_mode) <= 3'h2
    |-> pad_oe[7:6] == 2'b00) else $error("crystal pin driven");
  a_other_rst_dflt: assert property (other_reset_req |-> ##2
    ((pin_analog_mode & 8'h2f) == 8'h2f && (pad_oe & 8'h3f) == 8'h00))
    else $error("other reset defaults");
endmodule // pagpm_asserts
bind pagpm_top pagpm_asserts u_pagpm_asserts (.ref_clk, .rst_n, .other_reset_req, .pad_in,
  .pad_out, .pad_oe, .osc_mode, .clock_output_src, .pin_analog_mode, .pin_lcd_mode_active,
  .timer0_ext_clock_in, .slave_select_in, .timer1_osc_input, .timer1_control, .lcd_control);

// ===== tb/pagpm_pins.sv
// Purpose: outside world of the port: pad wires and a free clock source
// Assumes: ext_level is what outside parts drive onto released pads
// Notes:   a released pad shows the outside level, never the last driven one
`timescale 1ns/1ps
module pagpm_pins (
  input  wire       ref_clk,
  input  wire [7:0] pad_out,
  input  wire [7:0] pad_oe,
  input  wire [7:0] ext_level,
  output wire [7:0] pad_in,
  output reg        clock_output_src
);
  initial clock_output_src = 1'b0;
  always @(posedge ref_clk) begin
    clock_output_src <= ~clock_output_src;
  end
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule // pagpm_pins

// ===== tb/pagpm_tb_top.sv
// Purpose: self-checking bench of the port over AXI4-Lite
// Assumes: byte address is index times four, data in byte 0
// Notes:   ready is sampled mid-cycle, where it equals its value at the next edge
`timescale 1ns/1ps
`include "pagpm_regs.vh"
module pagpm_tb_top;
  reg        ref_clk = 0, rst_n = 0, other_reset_req = 0;
  reg [11:0] s_awaddr = 0, s_araddr = 0;
  reg        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  reg [31:0] s_wdata = 0;
  reg [3:0]  s_wstrb = 0;
  reg [2:0]  osc_mode = 3'h4;
  reg        has_fourth_port = 0, cmp1 = 0, cmp2 = 0;
  reg [7:0]  ext_level = 8'hff;
  wire       s_awready, s_wready, s_bvalid, s_arready, s_rvalid, clock_output_src;
  wire [1:0] s_bresp, s_rresp;
  wire [31:0] s_rdata;
  wire [7:0] pad_in, pad_out, pad_oe, pin_analog_mode, pin_lcd_mode_active;
  wire       timer0_ext_clock_in, slave_select_in, timer1_osc_input, crystal_input;
  wire [7:0] timer1_control, lcd_control, sync_serial_control, converter_control0;
  wire [7:0] option_settings;
  integer    n_errors = 0, checks = 0;
  always #25 ref_clk = ~ref_clk;
  pagpm_pins u_pagpm_pins (.ref_clk, .pad_out, .pad_oe, .ext_level, .pad_in, .clock_output_src);
  pagpm_top u_pagpm_top (.ref_clk, .rst_n, .other_reset_req, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .pad_in, .pad_out,
    .pad_oe, .osc_mode, .has_fourth_port, .comparator1_output(cmp1), .comparator2_output(cmp2),
    .clock_output_src, .pin_analog_mode, .pin_lcd_mode_active, .timer0_ext_clock_in,
    .slave_select_in, .crystal_input, .timer1_osc_input, .timer1_control,
    .sync_serial_control, .converter_control0, .option_settings, .lcd_control);
  task stop_test;
    begin
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task bus(input wr, input [9:0] idx, input [7:0] d, output [31:0] rd, output [1:0] resp);
    integer n;
    reg     done, aw, w, ar;
    begin
      done = 0;
      @(posedge ref_clk);
      if (wr) begin
        s_awaddr <= {idx, 2'b00};
        s_wdata <= {24'h00_0000, d};
        s_wstrb <= 4'hf;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
      end else begin
        s_araddr <= {idx, 2'b00};
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
      end
      for (n = 0; n < 64 && !done; n = n + 1) begin
        @(negedge ref_clk);
        aw = s_awvalid & s_awready;
        w = s_wvalid & s_wready;
        ar = s_arvalid & s_arready;
        if (s_bvalid & s_bready) begin
          resp = s_bresp;
          done = 1;
        end
        if (s_rvalid & s_rready) begin
          rd = s_rdata;
          resp = s_rresp;
          done = 1;
        end
        @(posedge ref_clk);
        if (aw) s_awvalid <= 1'b0;
        if (w) s_wvalid <= 1'b0;
        if (ar) s_arvalid <= 1'b0;
        if (done) begin
          s_bready <= 1'b0;
          s_rready <= 1'b0;
        end
      end
      if (!done) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: bus timeout", $time);
        stop_test;
      end
    end
  endtask
  task wr(input [9:0] i, input [7:0] d);
    reg [31:0] x;
    reg [1:0]  r;
    begin
      bus(1, i, d, x, r);
      chk(r, `PAGPM_RESP_OKAY);
    end
  endtask
  task rchk(input [9:0] i, input [31:0] e);
    reg [31:0] x;
    reg [1:0]  r;
    begin
      bus(0, i, 8'h00, x, r);
      chk(x, e);
      chk(r, `PAGPM_RESP_OKAY);
    end
  endtask
  task pause;
    repeat (3) @(negedge ref_clk);
  endtask
  task t_reset_vals;
    reg [31:0] x;
    reg [1:0]  r;
    begin
      rchk(`PAGPM_IDX_PORT_DIR, 32'h0000_00ff);
      rchk(`PAGPM_IDX_ANALOG_SEL, 32'h0000_00ff);
      rchk(`PAGPM_IDX_LCD_SE_LO, 32'h0000_0000);
      rchk(`PAGPM_IDX_LCD_CTRL, 32'h0000_0013);
      rchk(`PAGPM_IDX_PORT_DATA, 32'h0000_00d0);
      pause;
      chk(pad_oe, 8'h00);
      chk(option_settings, 8'hff);
      wr(`PAGPM_IDX_SSP_CTRL, 8'h3c);
      wr(`PAGPM_IDX_ADC_CTRL0, 8'h41);
      wr(`PAGPM_IDX_OPTION, 8'h7e);
      pause;
      chk(sync_serial_control, 8'h3c);
      chk(converter_control0, 8'h41);
      chk(option_settings, 8'h7e);
      bus(0, 10'h3ff, 8'h00, x, r);
      chk(r, `PAGPM_RESP_SLVERR);
      bus(1, 10'h3ff, 8'h55, x, r);
      chk(r, `PAGPM_RESP_SLVERR);
    end
  endtask
  task t_gpio;
    begin
      wr(`PAGPM_IDX_CMP_CTRL0, 8'h07);
      wr(`PAGPM_IDX_ANALOG_SEL, 8'h00);
      wr(`PAGPM_IDX_PORT_DATA, 8'ha5);
      @(posedge ref_clk) ext_level <= 8'h08;
      wr(`PAGPM_IDX_PORT_DIR, 8'h00);
      pause;
      chk(pad_oe, 8'hf7);
      chk(pad_out & 8'hf7, 8'ha5);
      rchk(`PAGPM_IDX_PORT_DATA, 32'h0000_00ad);
      wr(`PAGPM_IDX_PORT_DIR, 8'h0f);
      pause;
      chk(pad_oe, 8'hf0);
      rchk(`PAGPM_IDX_PORT_DATA, 32'h0000_00a8);
    end
  endtask
  task t_analog;
    begin
      wr(`PAGPM_IDX_ANALOG_SEL, 8'h1f);
      wr(`PAGPM_IDX_PORT_DIR, 8'h00);
      pause;
      chk(pin_analog_mode, 8'h2f);
      chk(pad_oe, 8'hf7);
      rchk(`PAGPM_IDX_PORT_DATA, 32'h0000_0080);
      wr(`PAGPM_IDX_ANALOG_SEL, 8'h00);
      wr(`PAGPM_IDX_CMP_CTRL0, 8'h00);
      pause;
      chk(pin_analog_mode, 8'h0f);
      wr(`PAGPM_IDX_CMP_CTRL0, 8'h07);
    end
  endtask
  task t_crystal;
    integer m;
    begin
      @(posedge ref_clk) ext_level <= 8'h88;
      for (m = 0; m < 4; m = m + 1) begin
        @(posedge ref_clk) osc_mode <= m;
        wr(`PAGPM_IDX_PORT_DIR, 8'h00);
        rchk(`PAGPM_IDX_PORT_DIR, (m < 3) ? 32'h0000_00c0 : 32'h0000_0000);
        chk(crystal_input, 1'b1);
      end
      @(posedge ref_clk) osc_mode <= 3'h5;
      pause;
      chk(pad_oe[6], 1'b1);
      @(posedge ref_clk) osc_mode <= 3'h7;
      pause;
      chk(pad_oe[6], 1'b1);
      @(posedge ref_clk) osc_mode <= 3'h4;
      pause;
      chk(crystal_input, 1'b0);
    end
  endtask
  task t_lcd;
    integer h, s;
    begin
      wr(`PAGPM_IDX_LCD_CTRL, 8'h83);
      for (h = 0; h < 2; h = h + 1)
        for (s = 0; s < 2; s = s + 1) begin
          @(posedge ref_clk) has_fourth_port <= h;
          wr(`PAGPM_IDX_LCD_SE_HI, s ? 8'h90 : 8'h10);
          pause;
          chk(pin_lcd_mode_active[3], (h == 0) || (s == 1));
          chk(pin_lcd_mode_active[0], 1'b1);
          chk(pin_lcd_mode_active[2], 1'b1);
          chk(pad_oe[0], 1'b0);
        end
      wr(`PAGPM_IDX_LCD_CTRL, 8'h03);
      pause;
      chk(pin_lcd_mode_active, 8'h00);
      wr(`PAGPM_IDX_LCD_SE_HI, 8'h00);
    end
  endtask
  task t_cmp;
    begin
      wr(`PAGPM_IDX_CMP_CTRL0, 8'h06);
      wr(`PAGPM_IDX_PORT_DIR, 8'hff);
      @(posedge ref_clk) cmp1 <= 1'b1;
      pause;
      chk(pad_oe[5:4], 2'b11);
      chk(pad_out[5:4], 2'b01);
      @(posedge ref_clk) cmp2 <= 1'b1;
      cmp1 <= 1'b0;
      pause;
      chk(pad_out[5:4], 2'b10);
      wr(`PAGPM_IDX_CMP_CTRL0, 8'h07);
    end
  endtask
  task t_other_rst;
    begin
      wr(`PAGPM_IDX_LCD_SE_LO, 8'h30);
      wr(`PAGPM_IDX_T1_CTRL, 8'h08);
      wr(`PAGPM_IDX_PORT_DATA, 8'h5a);
      @(posedge ref_clk) other_reset_req <= 1'b1;
      @(posedge ref_clk) other_reset_req <= 1'b0;
      pause;
      rchk(`PAGPM_IDX_LCD_SE_LO, 32'h0000_0030);
      rchk(`PAGPM_IDX_PORT_DIR, 32'h0000_00ff);
      rchk(`PAGPM_IDX_T1_CTRL, 32'h0000_0008);
      chk(sync_serial_control, 8'h00);
      chk(converter_control0, 8'h00);
      chk(option_settings, 8'hff);
      wr(`PAGPM_IDX_ANALOG_SEL, 8'h00);
      wr(`PAGPM_IDX_CMP_CTRL0, 8'h07);
      wr(`PAGPM_IDX_PORT_DIR, 8'h00);
      pause;
      chk(pad_out[2:0], 3'b010);
      chk(timer1_osc_input, 1'b1);
      @(posedge ref_clk) rst_n <= 1'b0;
      @(posedge ref_clk) rst_n <= 1'b1;
      rchk(`PAGPM_IDX_LCD_SE_LO, 32'h0000_0000);
    end
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset_vals;
    t_gpio;
    t_analog;
    t_crystal;
    t_lcd;
    t_cmp;
    t_other_rst;
    stop_test;
  end
endmodule // pagpm_tb_top
